// >>> mpfr_regs.sv
// Purpose: PHY management access, data and flow control registers with APB slave
// Assumes: APB master holds its request until pready; PHY port is a parallel handshake
// Notes: slave answers in the second access cycle; reserved bits read zero
//
// Summary of operation
// - Register index field selects the PHY register for the cycle.
// - Direction one writes data register to PHY; zero reads into it.
// - A PHY cycle starts only on software writing busy one.
// - Busy stays set through the access, cleared on completion.
// - Data register is invalid during a read until busy clears.
// - Data register holds sixteen bits in its low half.
// - Upper flow field is the pause time sent in pause frames.
// - Full duplex: flow busy from pause request until frame is sent.
// - Half duplex: flow busy while back pressure is asserted.
// - Pass-control-frames never blocks forwarding of received frames.
// - Flow enable turns on pause frame detection and action.
// - Disabled transmitter means no pause frames and no back pressure.
// - Pause frames follow the standard MAC control frame layout.
// - Valid received pause stalls transmitter for pause time times slot time.
// - Pass-control-frames set marks received pause frames in filter status.
`timescale 1ns/1ns
module mpfr_regs
    import mpfr_pkg::*;
#(
    parameter int SLOT_CYC_SLOW = SLOT_CYC_10
) (
    input wire logic CLK, // system clock
    input wire logic RESETN, // async reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction
    input wire logic [APB_AW-1:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // unmapped address
    output logic PHY_REQ, // management cycle request, level
    output logic PHY_WR, // management cycle is a write
    output logic [4:0] PHY_ADDR, // phy address
    output logic [4:0] PHY_REG, // phy register index
    output logic [15:0] PHY_WDATA, // data for a write
    input wire logic PHY_ACK, // management cycle done, pulse
    input wire logic [15:0] PHY_RDATA, // read result with ack
    input wire logic FULL_DUPLEX, // duplex mode
    input wire logic SPEED_100, // link speed
    input wire logic TX_ENABLE, // transmitter enabled
    input wire logic [47:0] STATION_ADDR, // own address, first byte in 47:40
    input wire logic PAUSE_REQ, // request to send a pause frame
    input wire logic BP_REQ, // half duplex back pressure request
    output logic [7:0] TX_PAUSE_BYTE, // pause frame header byte
    output logic TX_PAUSE_VALID, // header byte valid
    input wire logic TX_PAUSE_READY, // transmitter takes the byte
    input wire logic TX_PAUSE_SENT, // pause frame left the cable, pulse
    output logic BACKPRESSURE, // half duplex back pressure
    input wire logic RX_PAUSE_VALID, // valid pause frame received, pulse
    input wire logic [15:0] RX_PAUSE_TIME, // decoded pause time
    output logic TX_STALL, // transmitter paused
    output logic RX_FILTER_BIT, // packet filter status for last frame
    output logic RX_FILTER_VALID // filter status strobe
);

    initial begin
        if (SLOT_CYC_SLOW < 1) begin
            $error("slot cycle count must be positive");
        end
    end

    mpfr_state_t s_r;
    mpfr_state_t s_nxt;
    logic flow_busy;
    logic acc_first;
    logic acc_done;
    logic hit;
    logic rx_load;
    logic [31:0] rd_mux;

    // ==================================================
    // helpers
    function automatic logic [7:0] hdr_byte(input logic [4:0] idx, input logic [47:0] sa,
                                            input logic [15:0] pt);
        logic [143:0] hdr;
        hdr = {PAUSE_DA, sa, PAUSE_TYPE, PAUSE_OPCODE, pt};
        return hdr[8'(143 - 8 * int'(idx)) -: 8];
    endfunction : hdr_byte

    function automatic logic addr_hit(input logic [APB_AW-1:0] a);
        return a == ADDR_ACCESS || a == ADDR_DATA || a == ADDR_FLOW;
    endfunction : addr_hit

    // ==================================================
    // read view
    assign flow_busy = (s_r.pf != PF_IDLE) || s_r.bp;
    assign acc_first = PSEL && PENABLE && !s_r.pready;
    assign acc_done = PSEL && PENABLE && s_r.pready;
    assign hit = addr_hit(PADDR);
    assign rx_load = RX_PAUSE_VALID && s_r.flow_en && FULL_DUPLEX;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (PADDR)
            ADDR_ACCESS: begin
                rd_mux[ACC_PHYADR_MSB:ACC_PHYADR_LSB] = s_r.phy_addr;
                rd_mux[ACC_REGIDX_MSB:ACC_REGIDX_LSB] = s_r.phy_reg;
                rd_mux[ACC_WNR_BIT] = s_r.phy_wr;
                rd_mux[ACC_BUSY_BIT] = s_r.mg == MG_BUSY;
            end
            ADDR_DATA: begin
                rd_mux[DATA_MSB:0] = s_r.data;
            end
            ADDR_FLOW: begin
                rd_mux[FLOW_PT_MSB:FLOW_PT_LSB] = s_r.pause_time;
                rd_mux[FLOW_PASS_BIT] = s_r.pass_ctl;
                rd_mux[FLOW_EN_BIT] = s_r.flow_en;
                rd_mux[FLOW_BUSY_BIT] = flow_busy;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // ==================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.rx_filt_vld = 1'b0;

        // apb slave: answer in second access cycle
        if (acc_first) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = PWRITE ? 32'h0000_0000 : rd_mux;
            s_nxt.pslverr = !hit;
        end else begin
            s_nxt.pready = 1'b0;
            s_nxt.pslverr = 1'b0;
        end

        // management cycle
        unique case (s_r.mg)
            MG_IDLE: begin
                if (acc_done && PWRITE && PADDR == ADDR_ACCESS) begin
                    s_nxt.phy_addr = PWDATA[ACC_PHYADR_MSB:ACC_PHYADR_LSB];
                    s_nxt.phy_reg = PWDATA[ACC_REGIDX_MSB:ACC_REGIDX_LSB];
                    s_nxt.phy_wr = PWDATA[ACC_WNR_BIT];
                    if (PWDATA[ACC_BUSY_BIT]) begin
                        s_nxt.mg = MG_BUSY;
                    end
                end
                if (acc_done && PWRITE && PADDR == ADDR_DATA) begin
                    s_nxt.data = PWDATA[DATA_MSB:0];
                end
            end
            MG_BUSY: begin
                // access and data register writes ignored while busy, data stays stable for the phy
                if (PHY_ACK) begin
                    s_nxt.mg = MG_IDLE;
                    if (!s_r.phy_wr) begin
                        s_nxt.data = PHY_RDATA;
                    end
                end
            end
        endcase

        // flow control register, busy bit is never stored
        if (acc_done && PWRITE && PADDR == ADDR_FLOW) begin
            s_nxt.pause_time = PWDATA[FLOW_PT_MSB:FLOW_PT_LSB];
            s_nxt.pass_ctl = PWDATA[FLOW_PASS_BIT];
            s_nxt.flow_en = PWDATA[FLOW_EN_BIT];
        end

        // pause frame header stream
        unique case (s_r.pf)
            PF_IDLE: begin
                if (PAUSE_REQ && FULL_DUPLEX && TX_ENABLE) begin
                    s_nxt.pf = PF_SEND;
                    s_nxt.pf_idx = 5'h00;
                    s_nxt.pf_byte = hdr_byte(5'h00, STATION_ADDR, s_r.pause_time);
                    s_nxt.pf_valid = 1'b1;
                end
            end
            PF_SEND: begin
                if (TX_PAUSE_READY) begin
                    if (s_r.pf_idx == PAUSE_HDR_LAST) begin
                        s_nxt.pf = PF_WAIT;
                        s_nxt.pf_valid = 1'b0;
                    end else begin
                        s_nxt.pf_idx = s_r.pf_idx + 5'h01;
                        s_nxt.pf_byte = hdr_byte(s_r.pf_idx + 5'h01, STATION_ADDR,
                                                 s_r.pause_time);
                    end
                end
            end
            PF_WAIT: begin
                if (TX_PAUSE_SENT) begin
                    s_nxt.pf = PF_IDLE;
                end
            end
            default: begin
                s_nxt.pf = PF_IDLE;
                s_nxt.pf_valid = 1'b0;
            end
        endcase

        // half duplex back pressure
        s_nxt.bp = !FULL_DUPLEX && s_r.flow_en && TX_ENABLE && BP_REQ;

        // receive filter status; forwarding is never gated here
        if (RX_PAUSE_VALID) begin
            s_nxt.rx_filt = s_r.pass_ctl;
            s_nxt.rx_filt_vld = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s_r <= '0;
            s_r.mg <= MG_IDLE;
            s_r.pf <= PF_IDLE;
            s_r.data <= RST_DATA[DATA_MSB:0];
            s_r.phy_addr <= RST_ACCESS[ACC_PHYADR_MSB:ACC_PHYADR_LSB];
            s_r.phy_reg <= RST_ACCESS[ACC_REGIDX_MSB:ACC_REGIDX_LSB];
            s_r.pause_time <= RST_FLOW[FLOW_PT_MSB:FLOW_PT_LSB];
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==================================================
    // receive pause timer
    mpfr_pause_timer #(
        .SLOT_CYC_FAST(SLOT_CYC_100),
        .SLOT_CYC_SLOW(SLOT_CYC_SLOW)
    ) u_pause_timer (
        .clk(CLK),
        .resetn(RESETN),
        .load(rx_load),
        .quanta(RX_PAUSE_TIME),
        .speed_fast(SPEED_100),
        .active(TX_STALL)
    );

    // ==================================================
    // outputs
    assign PRDATA = s_r.prdata;
    assign PREADY = s_r.pready;
    assign PSLVERR = s_r.pslverr;
    assign PHY_REQ = s_r.mg == MG_BUSY;
    assign PHY_WR = s_r.phy_wr;
    assign PHY_ADDR = s_r.phy_addr;
    assign PHY_REG = s_r.phy_reg;
    assign PHY_WDATA = s_r.data;
    assign TX_PAUSE_BYTE = s_r.pf_byte;
    assign TX_PAUSE_VALID = s_r.pf_valid;
    assign BACKPRESSURE = s_r.bp;
    assign RX_FILTER_BIT = s_r.rx_filt;
    assign RX_FILTER_VALID = s_r.rx_filt_vld;

endmodule : mpfr_regs

// >>> mpfr_pkg.sv
// Purpose: shared constants and types for the PHY management and flow control registers
// Assumes: 32-bit APB data, one aligned word per register
// Notes: register offsets are word indices, byte address is four times the index
package mpfr_pkg;

    // ==================================================
    // register map
    localparam int APB_AW = 8;
    localparam int IDX_ACCESS = 6;
    localparam int IDX_DATA = 7;
    localparam int IDX_FLOW = 8;
    localparam logic [APB_AW-1:0] ADDR_ACCESS = 8'(IDX_ACCESS * 4);
    localparam logic [APB_AW-1:0] ADDR_DATA = 8'(IDX_DATA * 4);
    localparam logic [APB_AW-1:0] ADDR_FLOW = 8'(IDX_FLOW * 4);
    localparam logic [31:0] RST_ACCESS = 32'h0000_0000;
    localparam logic [31:0] RST_DATA = 32'h0000_0000;
    localparam logic [31:0] RST_FLOW = 32'h0000_0000;

    // ==================================================
    // field positions
    localparam int ACC_PHYADR_LSB = 11;
    localparam int ACC_PHYADR_MSB = 15;
    localparam int ACC_REGIDX_LSB = 6;
    localparam int ACC_REGIDX_MSB = 10;
    localparam int ACC_WNR_BIT = 1;
    localparam int ACC_BUSY_BIT = 0;
    localparam int DATA_MSB = 15;
    localparam int FLOW_PT_LSB = 16;
    localparam int FLOW_PT_MSB = 31;
    localparam int FLOW_PASS_BIT = 2;
    localparam int FLOW_EN_BIT = 1;
    localparam int FLOW_BUSY_BIT = 0;

    // ==================================================
    // pause control frame layout
    localparam logic [47:0] PAUSE_DA = 48'h0180_C200_0001;
    localparam logic [15:0] PAUSE_TYPE = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
    localparam logic [4:0] PAUSE_HDR_LAST = 5'h11;

    // ==================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLOT_TIME_100_NS = 5120;
    localparam int SLOT_TIME_10_NS = 51200;
    localparam int SLOT_CYC_100 = SLOT_TIME_100_NS / CLK_PERIOD_NS;
    localparam int SLOT_CYC_10 = SLOT_TIME_10_NS / CLK_PERIOD_NS;
    localparam int SLOT_CW = 16;

    // ==================================================
    // types
    typedef enum logic {MG_IDLE, MG_BUSY} mpfr_mgmt_t;
    typedef enum logic [1:0] {PF_IDLE, PF_SEND, PF_WAIT} mpfr_pf_t;

    typedef struct packed {
        mpfr_mgmt_t mg;
        logic [4:0] phy_addr;
        logic [4:0] phy_reg;
        logic phy_wr;
        logic [15:0] data;
        logic [15:0] pause_time;
        logic pass_ctl;
        logic flow_en;
        mpfr_pf_t pf;
        logic [4:0] pf_idx;
        logic [7:0] pf_byte;
        logic pf_valid;
        logic bp;
        logic rx_filt;
        logic rx_filt_vld;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } mpfr_state_t;

    typedef struct packed {
        logic [15:0] quanta;
        logic [SLOT_CW-1:0] cyc;
        logic active;
    } mpfr_tmr_state_t;

endpackage : mpfr_pkg

// >>> mpfr_pause_timer.sv
// Purpose: stalls the transmitter for pause quanta times slot time
// Assumes: load is a one-cycle pulse, quanta of zero ends any pause
// Notes: slot tick comes from an internal divider, no second clock
`timescale 1ns/1ns
module mpfr_pause_timer
    import mpfr_pkg::*;
#(
    parameter int SLOT_CYC_FAST = SLOT_CYC_100,
    parameter int SLOT_CYC_SLOW = SLOT_CYC_10
) (
    input wire logic clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic load, // start or restart a pause
    input wire logic [15:0] quanta, // decoded pause time
    input wire logic speed_fast, // 100 Mb/s when high
    output logic active // transmitter stall
);

    initial begin
        if (SLOT_CYC_FAST < 1 || SLOT_CYC_SLOW < 1 || SLOT_CYC_FAST >= (1 << SLOT_CW) ||
            SLOT_CYC_SLOW >= (1 << SLOT_CW)) begin
            $error("slot cycle count out of range");
        end
    end

    localparam logic [SLOT_CW-1:0] LAST_FAST = SLOT_CW'(SLOT_CYC_FAST - 1);
    localparam logic [SLOT_CW-1:0] LAST_SLOW = SLOT_CW'(SLOT_CYC_SLOW - 1);

    mpfr_tmr_state_t s_r;
    mpfr_tmr_state_t s_nxt;
    logic slot_tick;

    // ==================================================
    // slot divider and quanta countdown
    always_comb begin
        s_nxt = s_r;
        slot_tick = s_r.cyc == (speed_fast ? LAST_FAST : LAST_SLOW);
        if (load) begin
            s_nxt.quanta = quanta;
            s_nxt.cyc = '0;
            s_nxt.active = quanta != 16'h0000;
        end else if (s_r.active) begin
            s_nxt.cyc = slot_tick ? '0 : s_r.cyc + 1'b1;
            if (slot_tick) begin
                s_nxt.quanta = s_r.quanta - 16'h0001;
                s_nxt.active = s_r.quanta != 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign active = s_r.active;

endmodule : mpfr_pause_timer

// >>> mpfr_regs_properties.sv
// Purpose: port level checks of the management and flow control registers
// Assumes: single clock, asynchronous active low reset
// Notes: bound into every instance of the register block
`timescale 1ns/1ns
module mpfr_regs_properties
    import mpfr_pkg::*;
(
    input wire logic CLK, // clock
    input wire logic RESETN, // reset
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb enable
    input wire logic PWRITE, // apb direction
    input wire logic [APB_AW-1:0] PADDR, // apb address
    input wire logic [31:0] PWDATA, // apb write data
    input wire logic [31:0] PRDATA, // apb read data
    input wire logic PREADY, // apb ready
    input wire logic PSLVERR, // apb error
    input wire logic PHY_REQ, // phy request
    input wire logic PHY_WR, // phy direction
    input wire logic [4:0] PHY_ADDR, // phy address
    input wire logic [4:0] PHY_REG, // phy register
    input wire logic [15:0] PHY_WDATA, // phy write data
    input wire logic PHY_ACK, // phy done
    input wire logic FULL_DUPLEX, // duplex
    input wire logic TX_ENABLE, // tx enabled
    input wire logic PAUSE_REQ, // pause request
    input wire logic BP_REQ, // back pressure request
    input wire logic [7:0] TX_PAUSE_BYTE, // frame byte
    input wire logic TX_PAUSE_VALID, // byte valid
    input wire logic TX_PAUSE_READY, // byte taken
    input wire logic BACKPRESSURE, // back pressure
    input wire logic RX_PAUSE_VALID, // pause received
    input wire logic RX_FILTER_VALID // filter strobe
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // ==================================================
    // management cycle
    sequence s_go;
        PSEL && PENABLE && PREADY && PWRITE && PADDR == ADDR_ACCESS && PWDATA[0] && !PHY_REQ;
    endsequence
    sequence s_done;
        PHY_REQ && PHY_ACK;
    endsequence
    property p_go; s_go |=> PHY_REQ; endproperty
    a_go: assert property (p_go) else $error("no phy cycle after busy write");
    property p_spur;
        $rose(PHY_REQ) |-> $past(PSEL && PENABLE && PREADY && PWRITE && PADDR == ADDR_ACCESS);
    endproperty
    a_spur: assert property (p_spur) else $error("phy cycle without busy write");
    property p_done; s_done |=> !PHY_REQ; endproperty
    a_done: assert property (p_done) else $error("busy not cleared");
    property p_hold;
        PHY_REQ && !PHY_ACK |=> PHY_REQ && $stable({PHY_WR, PHY_ADDR, PHY_REG, PHY_WDATA});
    endproperty
    a_hold: assert property (p_hold) else $error("phy request dropped or changed");
    // ==================================================
    // register bus
    property p_err; PREADY && PSLVERR |-> PRDATA == 32'h0; endproperty
    a_err: assert property (p_err) else $error("error read not zero");
    property p_data;
        PREADY && !PWRITE && PADDR == ADDR_DATA |-> PRDATA[31:16] == 16'h0;
    endproperty
    a_data: assert property (p_data) else $error("data upper half not zero");
    // ==================================================
    // flow control
    property p_filt; RX_PAUSE_VALID |=> RX_FILTER_VALID; endproperty
    a_filt: assert property (p_filt) else $error("no filter strobe");
    property p_bp; BACKPRESSURE |-> $past(!FULL_DUPLEX && TX_ENABLE && BP_REQ); endproperty
    a_bp: assert property (p_bp) else $error("back pressure without cause");
    property p_tx;
        $rose(TX_PAUSE_VALID) |->
            TX_PAUSE_BYTE == 8'h01 && $past(PAUSE_REQ && FULL_DUPLEX && TX_ENABLE);
    endproperty
    a_tx: assert property (p_tx) else $error("bad pause frame start");
    property p_txh;
        TX_PAUSE_VALID && !TX_PAUSE_READY |=> TX_PAUSE_VALID && $stable(TX_PAUSE_BYTE);
    endproperty
    a_txh: assert property (p_txh) else $error("pause byte not held");
endmodule : mpfr_regs_properties

bind mpfr_regs mpfr_regs_properties u_props (.*);

// >>> mpfr_phy_model.sv
// Purpose: behavioural phy behind the parallel management port
// Assumes: request held until acknowledged
// Notes: read data is garbage except in the acknowledge cycle
`timescale 1ns/1ns
module mpfr_phy_model (
    input wire logic clk, // clock
    input wire logic resetn, // reset
    input wire logic req, // cycle request
    input wire logic wr, // write when high
    input wire logic [4:0] addr, // phy address
    input wire logic [4:0] regi, // register index
    input wire logic [15:0] wdata, // write data
    input wire logic slow, // answer late
    output logic ack, // cycle done
    output logic [15:0] rdata // read data
);
    logic [15:0] mem [32];
    int cnt;
    initial for (int i = 0; i < 32; i++) mem[i] = 16'(i);
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack <= 1'b0;
            cnt <= 0;
            rdata <= 16'hA5A5;
        end else begin
            ack <= 1'b0;
            rdata <= ~rdata;
            // only the phy at address one answers
            if (req && !ack && addr == 5'h01) begin
                if (cnt >= (slow ? 5 : 0)) begin
                    ack <= 1'b1;
                    cnt <= 0;
                    if (wr) mem[regi] <= wdata;
                    else rdata <= mem[regi];
                end else cnt <= cnt + 1;
            end
        end
    end
endmodule : mpfr_phy_model

// >>> mpfr_regs_tb.sv
// Purpose: self-checking bench for the management and flow control registers
// Assumes: short slot of 8 cycles at low speed
// Notes: apb master waits on pready, timeout ends a hang
`timescale 1ns/1ns
module mpfr_regs_tb
    import mpfr_pkg::*;
;
    logic CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA;
    logic PREADY, PSLVERR, PHY_REQ, PHY_WR, PHY_ACK, slow = 0;
    logic [4:0] PHY_ADDR, PHY_REG;
    logic [15:0] PHY_WDATA, PHY_RDATA, RX_PAUSE_TIME = 0;
    logic FULL_DUPLEX = 1, TX_ENABLE = 1, PAUSE_REQ = 0, BP_REQ = 0, TX_PAUSE_READY = 0;
    logic TX_PAUSE_SENT = 0, RX_PAUSE_VALID = 0, SPEED_100 = 0;
    logic [47:0] STATION_ADDR = 48'h1234_5678_9ABC;
    logic [7:0] TX_PAUSE_BYTE;
    logic TX_PAUSE_VALID, BACKPRESSURE, TX_STALL, RX_FILTER_BIT, RX_FILTER_VALID;
    int mismatches = 0, samples_checked = 0, cyc = 0, n;
    integer seed = 32'h294a2d81;
    logic [31:0] r, d;
    logic e;
    logic [4:0] idx;
    logic [15:0] pt;
    logic [143:0] fr;
    always #5 CLK = ~CLK;
    mpfr_regs #(.SLOT_CYC_SLOW(8)) dut (.*);
    mpfr_phy_model phy (.clk(CLK), .resetn(RESETN), .req(PHY_REQ), .wr(PHY_WR),
        .addr(PHY_ADDR), .regi(PHY_REG), .wdata(PHY_WDATA), .slow(slow), .ack(PHY_ACK),
        .rdata(PHY_RDATA));
    // ==================================================
    // helpers
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        samples_checked++;
        if (g !== x) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge CLK);
        PSEL <= 1;
        PENABLE <= 0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
    endtask : apb
    task automatic poll(input logic [7:0] a);
        do apb(0, a, 0); while (r[0] !== 1'b0);
    endtask : poll
    // one-cycle strobe on rx pause valid, pause sent, pause request
    task automatic pulse(input logic [2:0] m);
        @(posedge CLK);
        {RX_PAUSE_VALID, TX_PAUSE_SENT, PAUSE_REQ} <= m;
        @(posedge CLK);
        {RX_PAUSE_VALID, TX_PAUSE_SENT, PAUSE_REQ} <= 3'b000;
    endtask : pulse
    function automatic int stalls_exp(input logic [15:0] q, input logic en);
        return en ? q * 8 : 0;
    endfunction : stalls_exp
    // ==================================================
    // tests
    initial begin
        repeat (2) @(posedge CLK);
        RESETN <= 1;
        for (int i = 0; i < 3; i++) begin
            apb(0, ADDR_ACCESS + 8'(4 * i), 0);
            chk(r, 0, "reset value");
        end
        apb(0, 8'h40, 0);
        chk(r, 0, "unmapped data");
        chk(e, 1, "unmapped error");
        apb(1, ADDR_DATA, 32'hFFFFFFFF);
        apb(0, ADDR_DATA, 0);
        chk(r, 32'h0000FFFF, "data width");
        apb(1, ADDR_ACCESS, 32'hFFFF0FFE);
        apb(0, ADDR_ACCESS, 0);
        chk(r, 32'h00000FC2, "access reserved");
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            slow <= k[0];
            idx = 5'($random(seed));
            d = 32'($random(seed) & 32'hFFFF);
            apb(1, ADDR_DATA, d);
            apb(1, ADDR_ACCESS, {16'h0, 5'h01, idx, 6'h03});
            apb(0, ADDR_ACCESS, 0);
            chk(r[0], k[0], "busy during write");
            poll(ADDR_ACCESS);
            chk(phy.mem[idx], d, "phy written");
            apb(1, ADDR_DATA, 32'h0);
            apb(1, ADDR_ACCESS, {16'h0, 5'h01, idx, 6'h01});
            poll(ADDR_ACCESS);
            chk(r, {16'h0, 5'h01, idx, 6'h00}, "access after read");
            apb(0, ADDR_DATA, 0);
            chk(r, d, "read back");
        end
        $display("test phy done");
        pt = 16'($random(seed));
        apb(1, ADDR_FLOW, {pt, 16'hFFFE});
        apb(0, ADDR_FLOW, 0);
        chk(r, {pt, 16'h0006}, "flow reg");
        fr = {48'h0180C2000001, STATION_ADDR, 16'h8808, 16'h0001, pt};
        pulse(3'b001);
        for (int i = 0; i < 18; ) begin
            @(posedge CLK);
            if (TX_PAUSE_VALID === 1'b1 && TX_PAUSE_READY === 1'b1) begin
                chk(TX_PAUSE_BYTE, fr[143 - 8 * i -: 8], "frame byte");
                i++;
            end
            TX_PAUSE_READY <= 1'($random(seed));
        end
        apb(0, ADDR_FLOW, 0);
        chk(r[0], 1, "busy until sent");
        pulse(3'b010);
        poll(ADDR_FLOW);
        TX_ENABLE <= 0;
        pulse(3'b001);
        repeat (4) @(posedge CLK);
        chk(TX_PAUSE_VALID, 0, "no frame tx off");
        $display("test pause done");
        FULL_DUPLEX <= 0;
        BP_REQ <= 1;
        repeat (2) @(posedge CLK);
        chk(BACKPRESSURE, 0, "no bp tx off");
        TX_ENABLE <= 1;
        apb(0, ADDR_FLOW, 0);
        chk({BACKPRESSURE, r[0]}, 2'b11, "bp busy");
        BP_REQ <= 0;
        FULL_DUPLEX <= 1;
        $display("test backpressure done");
        for (int k = 0; k < 2; k++) begin
            poll(ADDR_FLOW);
            apb(1, ADDR_FLOW, {pt, 13'h0, 1'(k), 1'(k), 1'b0});
            RX_PAUSE_TIME <= 16'h3;
            pulse(3'b100);
            @(posedge CLK);
            chk({RX_FILTER_VALID, RX_FILTER_BIT}, {1'b1, 1'(k)}, "filter status");
            n = int'(TX_STALL === 1'b1);
            repeat (40) begin
                @(posedge CLK);
                n += int'(TX_STALL === 1'b1);
            end
            chk(n, stalls_exp(3, 1'(k)), "stall length");
        end
        SPEED_100 <= 1;
        RX_PAUSE_TIME <= 16'h1;
        pulse(3'b100);
        n = 0;
        repeat (600) begin
            @(posedge CLK);
            n += int'(TX_STALL === 1'b1);
        end
        chk(n, SLOT_CYC_100, "stall length fast");
        $display("test receive pause done");
        end_of_test();
    end
endmodule : mpfr_regs_tb
